// ==== inc/fpeg_pkg.sv ====
// constants and types shared by the flash program/erase guard
// assumes a single 250 MHz system clock and synchronous reset
package fpeg_pkg;
  localparam int CLK_NS        = 4;
  localparam int PROG_TIME_NS  = 40000;
  localparam int ERASE_TIME_NS = 20000000;
  localparam int PROG_CYC  = (PROG_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int ERASE_CYC = (ERASE_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int PAGE_BYTES  = 512;
  localparam int PAGE_BITS   = 9;
  localparam int PAGES       = 4;
  localparam int FLASH_BYTES = PAGE_BYTES * PAGES;
  localparam int FA_W        = 11;
  localparam logic [7:0] KEY_FIRST  = 8'ha5;
  localparam logic [7:0] KEY_SECOND = 8'hf1;
  localparam logic [7:0] ERASED     = 8'hff;
  localparam logic [7:0] OFS_CTL    = 8'h00;
  localparam logic [7:0] OFS_KEY    = 8'h04;
  localparam logic [7:0] OFS_MON    = 8'h08;
  localparam logic [7:0] OFS_RSRC   = 8'h0c;
  localparam logic [7:0] OFS_XADDR  = 8'h10;
  localparam logic [7:0] OFS_XDATA  = 8'h14;
  localparam logic [7:0] OFS_FREAD  = 8'h18;
  localparam logic [7:0] OFS_STAT   = 8'h1c;
  localparam int CTL_WE_BIT  = 0;
  localparam int CTL_EE_BIT  = 1;
  localparam int MON_EN_BIT  = 0;
  localparam int MON_LVL_BIT = 1;
  localparam int RSRC_MON_BIT  = 1;
  localparam int RSRC_FERR_BIT = 6;
  localparam logic [1:0]  CTL_RST   = 2'h0;
  localparam logic [1:0]  MON_RST   = 2'h0;
  localparam logic [15:0] XADDR_RST = 16'h0000;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    KEY_LOCKED = 2'b00,
    KEY_HALF   = 2'b01,
    KEY_OPEN   = 2'b10,
    KEY_DEAD   = 2'b11
  } fpeg_key_t;
  typedef enum logic [1:0] {
    OP_IDLE  = 2'b00,
    OP_PROG  = 2'b01,
    OP_ERASE = 2'b10
  } fpeg_op_t;
  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } fpeg_axi_req_t;
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } fpeg_axi_rsp_t;
endpackage

// ==== design/fpeg_key.sv ====
// two-code unlock sequencer for flash program/erase
// assumes key_wr, attempt and done are same-clock one-cycle pulses
`timescale 1ns/1ns
module fpeg_key (
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire logic             key_wr,
  input  wire logic [7:0]       key_val,
  input  wire logic             attempt,
  input  wire logic             done,
  output fpeg_pkg::fpeg_key_t   state
);
  fpeg_pkg::fpeg_key_t state_r;
  fpeg_pkg::fpeg_key_t state_nxt;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      fpeg_pkg::KEY_LOCKED: begin
        if (attempt) begin
          state_nxt = fpeg_pkg::KEY_DEAD;
        end else if (key_wr) begin
          state_nxt = (key_val == fpeg_pkg::KEY_FIRST) ?
            fpeg_pkg::KEY_HALF : fpeg_pkg::KEY_DEAD;
        end
      end
      fpeg_pkg::KEY_HALF: begin
        if (attempt) begin
          state_nxt = fpeg_pkg::KEY_DEAD;
        end else if (key_wr) begin
          state_nxt = (key_val == fpeg_pkg::KEY_SECOND) ?
            fpeg_pkg::KEY_OPEN : fpeg_pkg::KEY_DEAD;
        end
      end
      fpeg_pkg::KEY_OPEN: begin
        if (key_wr) begin
          state_nxt = fpeg_pkg::KEY_DEAD;
        end else if (done) begin
          state_nxt = fpeg_pkg::KEY_LOCKED;
        end
      end
      fpeg_pkg::KEY_DEAD: state_nxt = fpeg_pkg::KEY_DEAD;
      default: state_nxt = fpeg_pkg::KEY_DEAD;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_r <= fpeg_pkg::KEY_LOCKED;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign state = state_r;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence s_first_key;
    key_wr && !attempt && key_val == fpeg_pkg::KEY_FIRST &&
    state_r == fpeg_pkg::KEY_LOCKED;
  endsequence
  sequence s_second_key;
    key_wr && key_val == fpeg_pkg::KEY_SECOND;
  endsequence

  a_key_two_step: assert property (
    s_first_key ##1 (!key_wr && !attempt)[*3] ##1 s_second_key
    |=> state_r == fpeg_pkg::KEY_OPEN)
    else $error("correct key pair did not unlock");
  a_key_stays_dead: assert property (
    state_r == fpeg_pkg::KEY_DEAD |=> state_r == fpeg_pkg::KEY_DEAD)
    else $error("disabled lock left its state before reset");
  a_early_attempt: assert property (
    attempt && state_r != fpeg_pkg::KEY_OPEN
    |=> state_r == fpeg_pkg::KEY_DEAD)
    else $error("attempt without key did not disable");
  a_relock_done: assert property (
    done && !key_wr && state_r == fpeg_pkg::KEY_OPEN
    |=> state_r == fpeg_pkg::KEY_LOCKED)
    else $error("lock not restored after operation");
endmodule

// ==== design/fpeg_flash_array.sv ====
// byte-wide flash array held in flip-flops, page erase and and-program
// assumes prog and erase are one-cycle pulses that never coincide
`timescale 1ns/1ns
module fpeg_flash_array (
  input  wire logic                      sys_clk,
  input  wire logic                      reset,
  input  wire logic                      prog,
  input  wire logic                      erase,
  input  wire logic [fpeg_pkg::FA_W-1:0] waddr,
  input  wire logic [7:0]                wdata,
  input  wire logic [fpeg_pkg::FA_W-1:0] raddr,
  output logic      [7:0]                rdata
);
  localparam int PG_W = fpeg_pkg::FA_W - fpeg_pkg::PAGE_BITS;
  logic [7:0] mem_r [fpeg_pkg::FLASH_BYTES];

  // contents are non-volatile: reset leaves them alone
  for (genvar i = 0; i < fpeg_pkg::FLASH_BYTES; i++) begin : g_byte
    always_ff @(posedge sys_clk) begin
      if (erase && waddr[fpeg_pkg::FA_W-1:fpeg_pkg::PAGE_BITS] ==
          PG_W'(i / fpeg_pkg::PAGE_BYTES)) begin
        mem_r[i] <= fpeg_pkg::ERASED;
      end else if (prog && waddr == fpeg_pkg::FA_W'(i)) begin
        mem_r[i] <= mem_r[i] & wdata;
      end
    end
  end

  assign rdata = mem_r[raddr];

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  a_prog_and_only: assert property (
    prog |=> mem_r[$past(waddr)] == ($past(mem_r[waddr]) & $past(wdata)))
    else $error("programmed byte is not old and data");
  a_erase_page_ones: assert property (
    erase |=> mem_r[{$past(waddr[fpeg_pkg::FA_W-1:fpeg_pkg::PAGE_BITS]),
                     fpeg_pkg::PAGE_BITS'(0)}] == fpeg_pkg::ERASED)
    else $error("erased page start is not all ones");
endmodule

// ==== design/fpeg_top.sv ====
// flash program/erase guard: lock and key, supply check, timed stall
// assumes an axi4-lite master on sys_clk and external data memory
// that answers ext_mem_rdata combinationally for ext_mem_addr
//
// Summary of operation
// - programming can only clear bits, only erase sets them.
// - operations are timed inside and stall the cpu till done.
// - a flash access without the supply guard forces a reset.
// - the key takes the first code and then the second code.
// - a wrong or out-of-order code disables flash until reset.
// - an access with the supply guard on before the key is complete also disables it.
// - every finished operation locks the key again.
// - write enable steers external-move writes to flash.
// - write enable holds until software clears it.
// - flash is in 512-byte pages and erase sets a page to ones.
// - with both enables and the key, a write erases its page.
// - address and data of a program come from the move write.
// - with write enable alone one byte is programmed.
// - external-move reads always go to external data memory.
`timescale 1ns/1ns
module fpeg_top #(
  parameter int PROG_CYCLES  = fpeg_pkg::PROG_CYC,
  parameter int ERASE_CYCLES = fpeg_pkg::ERASE_CYC
) (
  input  wire logic                    sys_clk,
  input  wire logic                    reset,
  input  wire fpeg_pkg::fpeg_axi_req_t axi_req,
  output fpeg_pkg::fpeg_axi_rsp_t      axi_rsp,
  output logic                         cpu_stall,
  output logic                         flash_error_reset,
  output logic                         ext_mem_we,
  output logic                         ext_mem_re,
  output logic [15:0]                  ext_mem_addr,
  output logic [7:0]                   ext_mem_wdata,
  input  wire logic [7:0]              ext_mem_rdata
);
  logic                awready_r;
  logic                wready_r;
  logic                bvalid_r;
  logic [1:0]          bresp_r;
  logic                arready_r;
  logic                rvalid_r;
  logic [31:0]         rdata_r;
  logic [1:0]          rresp_r;
  logic [7:0]          waddr_r;
  logic [7:0]          wdata_r;
  logic                wlane_r;
  logic [1:0]          ctl_r;
  logic [1:0]          mon_r;
  logic                rsrc_mon_r;
  logic                ferr_flag_r;
  logic                ferr_rst_r;
  logic [15:0]         xaddr_r;
  logic                ext_we_r;
  logic                ext_re_r;
  logic [7:0]          ext_wd_r;
  fpeg_pkg::fpeg_op_t  op_r;
  logic [31:0]         cnt_r;
  logic [7:0]          opdata_r;
  logic [15:0]         opaddr_r;
  logic                stall_r;
  fpeg_pkg::fpeg_key_t key_state;
  logic                wr_fire;
  logic                rd_fire;
  logic                wr_ok;
  logic                mapped_w;
  logic                key_wr;
  logic                xwrite;
  logic                to_flash;
  logic                guard_ok;
  logic                attempt;
  logic                start;
  logic                done;
  logic [7:0]          flash_rd;
  logic [31:0]         rd_mux;
  logic                rd_ok;

  // write fires once address and data are held and no operation runs
  assign wr_fire  = !awready_r && !wready_r && !bvalid_r &&
                    op_r == fpeg_pkg::OP_IDLE;
  assign rd_fire  = axi_req.arvalid && arready_r;
  assign mapped_w = waddr_r == fpeg_pkg::OFS_CTL ||
                    waddr_r == fpeg_pkg::OFS_KEY ||
                    waddr_r == fpeg_pkg::OFS_MON ||
                    waddr_r == fpeg_pkg::OFS_RSRC ||
                    waddr_r == fpeg_pkg::OFS_XADDR ||
                    waddr_r == fpeg_pkg::OFS_XDATA;
  assign wr_ok    = wr_fire && wlane_r && mapped_w;
  assign key_wr   = wr_ok && waddr_r == fpeg_pkg::OFS_KEY;
  assign xwrite   = wr_ok && waddr_r == fpeg_pkg::OFS_XDATA;
  assign to_flash = xwrite && ctl_r[fpeg_pkg::CTL_WE_BIT];
  assign guard_ok = mon_r[fpeg_pkg::MON_EN_BIT] &&
                    mon_r[fpeg_pkg::MON_LVL_BIT] && rsrc_mon_r;
  assign attempt  = to_flash && guard_ok;
  assign start    = attempt && key_state == fpeg_pkg::KEY_OPEN;
  assign done     = op_r != fpeg_pkg::OP_IDLE && cnt_r == 32'h0;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      bvalid_r  <= 1'b0;
      bresp_r   <= fpeg_pkg::RESP_OKAY;
      waddr_r   <= 8'h00;
      wdata_r   <= 8'h00;
      wlane_r   <= 1'b0;
    end else begin
      if (axi_req.awvalid && awready_r) begin
        awready_r <= 1'b0;
        waddr_r   <= axi_req.awaddr;
      end
      if (axi_req.wvalid && wready_r) begin
        wready_r <= 1'b0;
        wdata_r  <= axi_req.wdata[7:0];
        wlane_r  <= axi_req.wstrb[0];
      end
      if (wr_fire) begin
        bvalid_r <= 1'b1;
        bresp_r  <= mapped_w ? fpeg_pkg::RESP_OKAY : fpeg_pkg::RESP_SLVERR;
      end else if (bvalid_r && axi_req.bready) begin
        bvalid_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  always_comb begin
    rd_ok  = 1'b1;
    rd_mux = 32'h0;
    case (axi_req.araddr)
      fpeg_pkg::OFS_CTL:   rd_mux = {30'h0, ctl_r};
      fpeg_pkg::OFS_KEY:   rd_mux = {30'h0, key_state};
      fpeg_pkg::OFS_MON:   rd_mux = {30'h0, mon_r};
      fpeg_pkg::OFS_RSRC: begin
        rd_mux[fpeg_pkg::RSRC_MON_BIT]  = rsrc_mon_r;
        rd_mux[fpeg_pkg::RSRC_FERR_BIT] = ferr_flag_r;
      end
      fpeg_pkg::OFS_XADDR: rd_mux = {16'h0, xaddr_r};
      fpeg_pkg::OFS_XDATA: rd_mux = {24'h0, ext_mem_rdata};
      fpeg_pkg::OFS_FREAD: rd_mux = {24'h0, flash_rd};
      fpeg_pkg::OFS_STAT:  rd_mux = {30'h0, op_r};
      default:             rd_ok  = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0;
      rresp_r   <= fpeg_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rdata_r   <= rd_mux;
      rresp_r   <= rd_ok ? fpeg_pkg::RESP_OKAY : fpeg_pkg::RESP_SLVERR;
    end else if (rvalid_r && axi_req.rready) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
    end
  end

  // control, supply guard and address registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ctl_r      <= fpeg_pkg::CTL_RST;
      mon_r      <= fpeg_pkg::MON_RST;
      rsrc_mon_r <= 1'b0;
      xaddr_r    <= fpeg_pkg::XADDR_RST;
    end else if (wr_ok) begin
      case (waddr_r)
        fpeg_pkg::OFS_CTL:   ctl_r <= wdata_r[1:0];
        fpeg_pkg::OFS_MON:   mon_r <= wdata_r[1:0];
        fpeg_pkg::OFS_RSRC:  rsrc_mon_r <= wdata_r[fpeg_pkg::RSRC_MON_BIT];
        fpeg_pkg::OFS_XADDR: xaddr_r <= {xaddr_r[7:0], wdata_r};
        default:             ctl_r <= ctl_r;
      endcase
    end
  end

  // flash access without the supply guard raises the error reset
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ferr_rst_r  <= 1'b0;
      ferr_flag_r <= 1'b0;
    end else begin
      ferr_rst_r <= to_flash && !guard_ok;
      if (to_flash && !guard_ok) begin
        ferr_flag_r <= 1'b1;
      end
    end
  end

  // moves that do not target flash go to external data memory
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ext_we_r <= 1'b0;
      ext_re_r <= 1'b0;
      ext_wd_r <= 8'h00;
    end else begin
      ext_we_r <= xwrite && !ctl_r[fpeg_pkg::CTL_WE_BIT];
      ext_re_r <= rd_fire &&
                  axi_req.araddr == fpeg_pkg::OFS_XDATA;
      if (xwrite) begin
        ext_wd_r <= wdata_r;
      end
    end
  end

  // operation timer; the bus write path is held while busy
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      op_r     <= fpeg_pkg::OP_IDLE;
      cnt_r    <= 32'h0;
      opdata_r <= 8'h00;
      opaddr_r <= 16'h0000;
      stall_r  <= 1'b0;
    end else if (start) begin
      if (ctl_r[fpeg_pkg::CTL_EE_BIT]) begin
        op_r  <= fpeg_pkg::OP_ERASE;
        cnt_r <= 32'(ERASE_CYCLES - 1);
      end else begin
        op_r  <= fpeg_pkg::OP_PROG;
        cnt_r <= 32'(PROG_CYCLES - 1);
      end
      opaddr_r <= xaddr_r;
      opdata_r <= wdata_r;
      stall_r  <= 1'b1;
    end else if (done) begin
      op_r    <= fpeg_pkg::OP_IDLE;
      stall_r <= 1'b0;
    end else if (op_r != fpeg_pkg::OP_IDLE) begin
      cnt_r <= cnt_r - 32'h1;
    end
  end

  fpeg_key u_key (
    .sys_clk (sys_clk),
    .reset   (reset),
    .key_wr  (key_wr),
    .key_val (wdata_r),
    .attempt (attempt),
    .done    (done),
    .state   (key_state)
  );

  fpeg_flash_array u_flash (
    .sys_clk (sys_clk),
    .reset   (reset),
    .prog    (done && op_r == fpeg_pkg::OP_PROG),
    .erase   (done && op_r == fpeg_pkg::OP_ERASE),
    .waddr   (opaddr_r[fpeg_pkg::FA_W-1:0]),
    .wdata   (opdata_r),
    .raddr   (xaddr_r[fpeg_pkg::FA_W-1:0]),
    .rdata   (flash_rd)
  );

  assign axi_rsp.awready   = awready_r;
  assign axi_rsp.wready    = wready_r;
  assign axi_rsp.bvalid    = bvalid_r;
  assign axi_rsp.bresp     = bresp_r;
  assign axi_rsp.arready   = arready_r;
  assign axi_rsp.rvalid    = rvalid_r;
  assign axi_rsp.rdata     = rdata_r;
  assign axi_rsp.rresp     = rresp_r;
  assign cpu_stall         = stall_r;
  assign flash_error_reset = ferr_rst_r;
  assign ext_mem_we        = ext_we_r;
  assign ext_mem_re        = ext_re_r;
  assign ext_mem_addr      = xaddr_r;
  assign ext_mem_wdata     = ext_wd_r;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  a_stall_while_busy: assert property (
    start |=> stall_r && op_r != fpeg_pkg::OP_IDLE && !wr_fire)
    else $error("operation started without cpu stall");
  a_supply_guard_reset: assert property (
    to_flash && !guard_ok |=> flash_error_reset && op_r == fpeg_pkg::OP_IDLE)
    else $error("unguarded flash access did not force reset");
  a_write_steer: assert property (
    to_flash |=> !ext_mem_we)
    else $error("flash-bound move reached external memory");
  a_we_holds: assert property (
    !(wr_ok && waddr_r == fpeg_pkg::OFS_CTL) |=> $stable(ctl_r))
    else $error("write enable changed without a control write");
  a_erase_select: assert property (
    start && ctl_r[fpeg_pkg::CTL_EE_BIT] |=> op_r == fpeg_pkg::OP_ERASE)
    else $error("both enables did not start an erase");
  a_read_external: assert property (
    rd_fire && axi_req.araddr == fpeg_pkg::OFS_XDATA
    |=> ext_mem_re ##1 !ext_mem_re)
    else $error("move read not sent to external memory");
  a_op_operands: assert property (
    start |=> opaddr_r == $past(xaddr_r) && opdata_r == $past(wdata_r))
    else $error("operation did not take the move operands");
  a_prog_select: assert property (
    start && !ctl_r[fpeg_pkg::CTL_EE_BIT] |=> op_r == fpeg_pkg::OP_PROG)
    else $error("write enable alone did not start a program");
endmodule

// ==== sim/fpeg_xmem_model.sv ====
// external data memory model that answers the guard's move cycles
// assumes one-cycle write strobes on sys_clk and a combinational read
`timescale 1ns/1ns
module fpeg_xmem_model (
  input  wire logic        sys_clk,
  input  wire logic        we,
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  wdata,
  output logic      [7:0]  rdata
);
  logic [7:0] mem [256];

  // inverted-address start pattern, non-zero except at 255, so a stale or default read is noticed
  initial for (int i = 0; i < 256; i++) mem[i] = ~8'(i);

  always @(posedge sys_clk) begin
    if (we === 1'b1) mem[addr[7:0]] <= wdata;
  end

  assign rdata = mem[addr[7:0]];
endmodule

// ==== sim/tb.sv ====
// self-checking bench for the flash program/erase guard
// assumes the guard package and design files are compiled before it
`timescale 1ns/1ns
module tb;
  localparam int NPROG = 20;
  localparam int NERASE = 40;
  localparam int LIMIT = 40000;
  localparam logic [7:0] CTL = fpeg_pkg::OFS_CTL;
  localparam logic [7:0] KEY = fpeg_pkg::OFS_KEY;
  localparam logic [7:0] MON = fpeg_pkg::OFS_MON;
  localparam logic [7:0] RSRC = fpeg_pkg::OFS_RSRC;
  localparam logic [7:0] XA = fpeg_pkg::OFS_XADDR;
  localparam logic [7:0] XD = fpeg_pkg::OFS_XDATA;
  localparam logic [7:0] FRD = fpeg_pkg::OFS_FREAD;
  localparam logic [31:0] WE = 32'h1 << fpeg_pkg::CTL_WE_BIT;
  localparam logic [31:0] EE = 32'h1 << fpeg_pkg::CTL_EE_BIT;
  localparam logic [31:0] MEN = 32'h1 << fpeg_pkg::MON_EN_BIT;
  localparam logic [31:0] MLV = 32'h1 << fpeg_pkg::MON_LVL_BIT;
  localparam logic [31:0] RSM = 32'h1 << fpeg_pkg::RSRC_MON_BIT;
  localparam logic [31:0] FERR = 32'h1 << fpeg_pkg::RSRC_FERR_BIT;

  logic                    sys_clk;
  logic                    reset;
  fpeg_pkg::fpeg_axi_req_t req;
  fpeg_pkg::fpeg_axi_rsp_t rsp;
  logic                    cpu_stall;
  logic                    flash_error_reset;
  logic                    ext_mem_we;
  logic                    ext_mem_re;
  logic [15:0]             ext_mem_addr;
  logic [7:0]              ext_mem_wdata;
  logic [7:0]              ext_mem_rdata;
  logic [7:0]              model [fpeg_pkg::FLASH_BYTES];
  logic [31:0]             rnd;
  logic [31:0]             d;
  logic [1:0]              r;
  int                      miscompares;
  int                      n_tests;
  int                      cycles;
  int                      n_stall, n_we, n_re, n_ferr, s0;

  fpeg_top #(.PROG_CYCLES(NPROG), .ERASE_CYCLES(NERASE)) u_dut (
    .sys_clk(sys_clk), .reset(reset), .axi_req(req), .axi_rsp(rsp),
    .cpu_stall(cpu_stall), .flash_error_reset(flash_error_reset),
    .ext_mem_we(ext_mem_we), .ext_mem_re(ext_mem_re),
    .ext_mem_addr(ext_mem_addr), .ext_mem_wdata(ext_mem_wdata),
    .ext_mem_rdata(ext_mem_rdata));

  fpeg_xmem_model u_xmem (
    .sys_clk(sys_clk), .we(ext_mem_we), .addr(ext_mem_addr),
    .wdata(ext_mem_wdata), .rdata(ext_mem_rdata));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // event counters and hang guard
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    n_stall <= n_stall + int'(cpu_stall === 1'b1);
    n_we <= n_we + int'(ext_mem_we === 1'b1);
    n_re <= n_re + int'(ext_mem_re === 1'b1);
    n_ferr <= n_ferr + int'(flash_error_reset === 1'b1);
    if (cycles == LIMIT) begin
      miscompares = miscompares + 1;
      end_of_test();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ ({32{x[31]}} & 32'h04c11db7);
  endfunction

  task automatic step();
    rnd = lfsr(rnd);
  endtask

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] dat,
                    output logic [1:0] resp);
    logic done;
    done = 1'b0;
    @(posedge sys_clk);
    req <= '{1'b1, a, 1'b1, dat, 4'hf, 1'b1, 1'b0, 8'h00, 1'b0};
    while (!done) begin
      @(posedge sys_clk);
      if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
      if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
      if (rsp.bvalid === 1'b1) begin
        resp = rsp.bresp;
        req.bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] dat,
                    output logic [1:0] resp);
    logic done;
    done = 1'b0;
    @(posedge sys_clk);
    req <= '{1'b0, 8'h00, 1'b0, 32'h0, 4'h0, 1'b0, 1'b1, a, 1'b1};
    while (!done) begin
      @(posedge sys_clk);
      if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
      if (rsp.rvalid === 1'b1) begin
        dat = rsp.rdata;
        resp = rsp.rresp;
        req.rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic w(input logic [7:0] a, input logic [31:0] dat);
    logic [1:0] resp;
    wr(a, dat, resp);
  endtask

  task automatic rchk(input string what, input logic [7:0] a,
                      input logic [31:0] exp);
    logic [31:0] dat;
    logic [1:0]  resp;
    rd(a, dat, resp);
    check(what, dat, exp);
  endtask

  task automatic seta(input logic [15:0] a);
    w(XA, {24'h0, a[15:8]});
    w(XA, {24'h0, a[7:0]});
  endtask

  task automatic unlock();
    w(KEY, {24'h0, fpeg_pkg::KEY_FIRST});
    w(KEY, {24'h0, fpeg_pkg::KEY_SECOND});
  endtask

  task automatic guard_on();
    w(MON, MEN);
    w(MON, MEN | MLV);
    w(RSRC, RSM);
  endtask

  task automatic do_reset();
    reset <= 1'b1;
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
  endtask

  // full software sequence for one flash operation, key already handled
  task automatic flash_op(input logic [15:0] a, input logic [7:0] dat,
                          input logic ee, input logic [1:0] kexp);
    int s;
    int e;
    int n;
    n = ee ? NERASE : NPROG;
    w(CTL, ee ? EE : 32'h0);
    w(CTL, ee ? EE | WE : WE);
    seta(a);
    s = n_stall;
    e = n_we;
    w(XD, {24'h0, dat});
    rchk("op status", fpeg_pkg::OFS_STAT,
         kexp != 2'h0 ? 32'h0 : ee ? 32'h2 : 32'h1);
    // let the timed operation run out before counting its stall cycles
    repeat (n + 3) @(posedge sys_clk);
    if (kexp == 2'h0)
      check("stall", 32'((n_stall - s) inside {[n - 1:n]}), 1);
    else
      check("no stall", n_stall - s, 0);
    check("no ext write", n_we - e, 0);
    rchk("enable kept", CTL, ee ? EE | WE : WE);
    rchk("key after op", KEY, 32'(kexp));
    w(CTL, 32'h0);
    if (kexp == 2'h0) begin
      if (ee)
        for (int i = 0; i < fpeg_pkg::PAGE_BYTES; i++)
          model[{a[10:9], 9'(i)}] = fpeg_pkg::ERASED;
      else
        model[a[10:0]] = model[a[10:0]] & dat;
    end
    rchk("flash byte", FRD, {24'h0, model[a[10:0]]});
  endtask

  initial begin
    reset = 1'b1;
    req = '0;
    rnd = 32'heab0251d;
    do_reset();
    for (int i = 0; i < 8; i++)
      if (i != 5 && i != 6) rchk("reset value", 8'(4 * i), 0);
    rd(8'h20, d, r);
    check("unmapped data", d, 0);
    check("unmapped resp", r, fpeg_pkg::RESP_SLVERR);
    wr(FRD, 32'h0, r);
    check("read-only resp", r, fpeg_pkg::RESP_SLVERR);
    guard_on();
    rchk("monitor", MON, MEN | MLV);
    w(KEY, {24'h0, fpeg_pkg::KEY_FIRST});
    rchk("key half", KEY, 32'h1);
    w(KEY, {24'h0, fpeg_pkg::KEY_SECOND});
    rchk("key open", KEY, 32'h2);
    for (int p = 0; p < fpeg_pkg::PAGES; p++) begin
      if (p > 0) unlock();
      step();
      flash_op({rnd[20:16], 2'(p), rnd[8:0]}, rnd[15:8], 1'b1, 2'h0);
    end
    for (int i = 0; i < 10; i++) begin
      step();
      unlock();
      flash_op(i < 2 ? 16'h03ff : rnd[15:0], i == 0 ? 8'hf0 : rnd[23:16],
               1'b0, 2'h0);
    end
    unlock();
    flash_op(16'h0200 | 16'(rnd[8:0]), 8'h00, 1'b1, 2'h0);
    for (int i = 0; i < 12; i++) begin
      step();
      seta(rnd[15:0]);
      rchk("flash sweep", FRD, {24'h0, model[rnd[10:0]]});
    end
    seta(16'h1234);
    s0 = n_we;
    w(XD, 32'h5a);
    repeat (3) @(posedge sys_clk);
    check("ext write", n_we - s0, 1);
    w(CTL, WE);
    s0 = n_re;
    rchk("move read", XD, 32'h5a);
    repeat (3) @(posedge sys_clk);
    check("ext read", n_re - s0, 1);
    w(CTL, 32'h0);
    unlock();
    for (int i = 0; i < 3; i++) begin
      w(RSRC, i == 2 ? 32'h0 : RSM);
      w(MON, i == 0 ? MLV : i == 1 ? MEN : MEN | MLV);
      s0 = n_ferr;
      flash_op(16'h0400, 8'h00, 1'b0, 2'h2);
      check("error reset", n_ferr - s0, 1);
      rchk("error flag", RSRC, FERR | (i == 2 ? 32'h0 : RSM));
    end
    guard_on();
    flash_op(16'h0400, 8'h81, 1'b0, 2'h0);
    unlock();
    flash_op(16'h0700, 8'h00, 1'b1, 2'h0);
    for (int j = 0; j < 3; j++) begin
      do_reset();
      guard_on();
      if (j == 0) begin
        w(KEY, {24'h0, fpeg_pkg::KEY_FIRST});
        w(KEY, 32'h12);
      end
      if (j == 1) w(KEY, {24'h0, fpeg_pkg::KEY_SECOND});
      if (j == 2) flash_op(16'h0600, 8'h00, 1'b0, 2'h3);
      rchk("key dead", KEY, 32'h3);
      unlock();
      flash_op(16'h0600 | 16'(j), 8'h00, 1'b0, 2'h3);
    end
    end_of_test();
  end
endmodule
